// [verilog/stc_sweep_timebase.sv]
// How it works
// - Delay-active output high only in measurement, for whole delay count.
// - Pre-delay: count delay after qualified trigger, then start sweep.
// - Post-delay: count delay after each sweep before next sweep.
// - External trigger with post-delay: first trigger after delay starts.
// - Abort pulse ends sweep when the current memory cycle completes.
// - Triggers during sweep or post-delay are ignored.
// - Trigger qualified on rising or falling edge per slope setting.
// - Cursor-reset pulse clears cursor address scaler to zero.
// - 2 us active-low cursor pulse when sweep enters selected address.
// - Cursor inhibit grounded: cursor follows readout address instead.
// - Each recognised advance event gives one sample, next address.
// - Advance pulses recognised only with external-step decade chosen.
// - Advance pulses divided by dwell digits 1..9999.
// - External clock divided by ten, then by dwell digits and decade.
// - Internal-clock inhibit stops internal timebase use.
// - Per-sample strobe is presented on an output.
// - Sweep-active high exactly for each measurement sweep.
// - Grounded external stop requests stop in measure and readout.
// - With slope trigger, readout-trigger falling edge starts readout.
// - Extra delay (slope trigger, post-delay): withhold accumulation for selector-value dwell periods.
// - Extra-delay cycle: sweep flag, wait, acquire, post-delay, restart.
// - Sample period is four digits scaled by a decade multiplier.
// - External clock: delay counted in ten-period units times setting.
// - Delay off: sweep starts at once on trigger or completion.
// - Auto mode: start on command and each completion until limit.
`timescale 1ns/1ps
`default_nettype none
module stc_sweep_timebase (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire stc_pkg::stc_cfg_t cfg,
  input  wire logic             measureStart,
  input  wire logic             measureMode,
  input  wire logic             readoutMode,
  input  wire logic             memCycleDone,
  input  wire logic [16:0]      readoutAddr,
  input  wire logic             extTrigIn,
  input  wire logic             sweepAbortIn,
  input  wire logic             cursorResetIn,
  input  wire logic             measCursorInhibitN,
  input  wire logic             ext_step_in,
  input  wire logic             extClockIn,
  input  wire logic             intClockInhibitN,
  input  wire logic             extStopN,
  input  wire logic             readoutTrigIn,
  input  wire logic             pre_acq_wait_enableN,
  output logic                  delayActive,
  output logic                  sweepActive,
  output logic                  dwellOut,
  output logic                  accumStrobe,
  output logic [16:0]           sampleAddr,
  output logic                  cursorOutN,
  output logic                  stopRequest,
  output logic                  readoutStart,
  output logic [23:0]           sweepsDone
);
  import stc_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] syncA;
  logic [NSYNC-1:0] syncB;
  logic [NSYNC-1:0] syncC;
  assign pinRaw = {extTrigIn, sweepAbortIn, cursorResetIn,
                   measCursorInhibitN, ext_step_in, extClockIn,
                   intClockInhibitN, extStopN, readoutTrigIn,
                   pre_acq_wait_enableN};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= '1;
      syncB <= '1;
      syncC <= '1;
    end else begin
      syncA <= pinRaw;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  logic trigLvl;
  logic trigPrev;
  logic abortRise;
  logic curRstFall;
  logic curInhib;
  logic stepRise;
  logic clkRise;
  logic useExtClk;
  logic stopReq;
  logic rdTrigFall;
  logic extraEn;
  assign trigLvl    = syncB[9];
  assign trigPrev   = syncC[9];
  assign abortRise  = syncB[8] & ~syncC[8];
  assign curRstFall = ~syncB[7] & syncC[7];
  assign curInhib   = ~syncB[6];
  assign stepRise   = syncB[5] & ~syncC[5];
  assign clkRise    = syncB[4] & ~syncC[4];
  assign useExtClk  = ~syncB[3];
  assign stopReq    = ~syncB[2];
  assign rdTrigFall = ~syncB[1] & syncC[1];
  assign extraEn    = ~syncB[0];

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  function automatic logic [31:0] pow10(input logic [2:0] d);
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(d)) begin
        r = r * 32'd10;
      end
    end
    return r;
  endfunction : pow10

  function automatic logic [31:0] digitsOrOne(input logic [13:0] d);
    return (d == 14'h0) ? 32'h1 : {18'h0, d};
  endfunction : digitsOrOne

  logic usTick;
  logic extTen;
  logic baseTick;
  logic extStepMode;
  logic dwellTick;
  logic dwellDivTick;
  logic stepDivTick;
  logic delayDone;
  logic delayClr;
  logic dwellClr;
  logic stateChange;

  // Internal microsecond tick, or external clock prescaled by ten.
  // Microsecond tick restarted on every state change so internal delays and dwells are exact.
  stc_divider u_us (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (stateChange),
    .inTick  (1'b1),
    .divisor (32'(US_CYCLES)),
    .outTick (usTick)
  );
  stc_divider u_ext10 (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (~useExtClk),
    .inTick  (clkRise),
    .divisor (32'(EXT_PRESCALE)),
    .outTick (extTen)
  );
  assign baseTick    = useExtClk ? extTen : usTick;
  assign extStepMode = (cfg.dwellDecade == DECADE_EXT_STEP);

  stc_divider u_dwell (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (dwellClr),
    .inTick  (baseTick),
    // Period is digits times decade
    .divisor (32'(digitsOrOne(cfg.dwellDigits) * pow10(cfg.dwellDecade))),
    .outTick (dwellDivTick)
  );
  stc_divider u_step (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (~extStepMode),
    .inTick  (stepRise & extStepMode),
    .divisor (digitsOrOne(cfg.dwellDigits)),
    .outTick (stepDivTick)
  );
  assign dwellTick = extStepMode ? stepDivTick : dwellDivTick;

  stc_divider u_delay (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clear   (delayClr),
    .inTick  (baseTick),
    .divisor (32'(digitsOrOne(cfg.delayDigits) * pow10(cfg.delayDecade))),
    .outTick (delayDone)
  );

  // ------------------------------------------------------------
  // Sweep sequencer
  // ------------------------------------------------------------
  typedef struct packed {
    stc_state_t  st;
    logic [16:0] addr;
    logic [16:0] extraCnt;
    logic [23:0] sweeps;
    logic        abortPend;
    logic        strobe;
    logic        dwell;
    logic [16:0] curCnt;
    logic [15:0] curTimer;
    logic        curHit;
    logic        rdStart;
    logic        stopOut;
  } stc_core_t;

  stc_core_t c_reg;
  stc_core_t c_next;

  logic trigQual;
  logic slopeMode;
  logic limitHit;
  logic curMatch;
  logic [16:0] curSrc;
  logic newSweep;
  stc_state_t afterTrig;

  assign slopeMode = (cfg.trigMode != TRIG_AUTO);
  assign trigQual = (cfg.trigMode == TRIG_POS) ? (trigLvl & ~trigPrev) :
                    (cfg.trigMode == TRIG_NEG) ? (~trigLvl & trigPrev) :
                    1'b0;
  assign limitHit = (cfg.sweepCountLimit != 24'h0) &&
                    (c_reg.sweeps >= cfg.sweepCountLimit);
  assign afterTrig = (cfg.dlyMode == DLY_PRE) ? ST_PRE_DLY : ST_SWEEP;
  assign delayClr = !(c_reg.st == ST_PRE_DLY || c_reg.st == ST_POST_DLY);
  // First sample of a sweep gets a full dwell period on the internal time base
  assign dwellClr    = extStepMode || (c_reg.st != ST_SWEEP);
  assign stateChange = (c_next.st != c_reg.st);

  always_comb begin
    c_next = c_reg;
    newSweep = 1'b0;
    c_next.strobe  = 1'b0;
    c_next.dwell   = dwellTick;
    c_next.rdStart = readoutMode & slopeMode & rdTrigFall;
    c_next.stopOut = stopReq & (measureMode | readoutMode);
    if (abortRise) begin
      c_next.abortPend = 1'b1;
    end
    case (c_reg.st)
      ST_IDLE: begin
        c_next.abortPend = 1'b0;
        if (measureStart && measureMode && !limitHit) begin
          c_next.st = slopeMode ? ST_WAIT_TRIG : afterTrig;
        end
      end
      ST_WAIT_TRIG: begin
        if (trigQual) begin
          c_next.st = afterTrig;
        end
      end
      ST_PRE_DLY: begin
        if (delayDone) begin
          c_next.st = ST_SWEEP;
        end
      end
      ST_SWEEP: begin
        // Abort waits for the memory cycle so no sample is torn
        if (c_reg.abortPend && memCycleDone) begin
          c_next.st = ST_IDLE;
          c_next.abortPend = 1'b0;
        end else if (c_reg.extraCnt != 17'h0) begin
          if (dwellTick) begin
            c_next.extraCnt = c_reg.extraCnt - 17'h1;
          end
        end else if (dwellTick) begin
          c_next.strobe = 1'b1;
          c_next.addr = c_reg.addr + 17'h1;
          if (c_reg.addr + 17'h1 >= cfg.dataPoints) begin
            c_next.sweeps = c_reg.sweeps + 24'h1;
            c_next.addr = ADDR_RESET;
            newSweep = 1'b1;
            if (cfg.dlyMode == DLY_POST) begin
              c_next.st = ST_POST_DLY;
            end else if (stopReq || c_reg.sweeps + 24'h1 >=
                         cfg.sweepCountLimit && cfg.sweepCountLimit != 0) begin
              c_next.st = ST_IDLE;
            end else begin
              c_next.st = slopeMode ? ST_WAIT_TRIG : afterTrig;
            end
          end
        end
      end
      ST_POST_DLY: begin
        // Triggers are not watched here, so they are dropped
        if (delayDone) begin
          if (stopReq || limitHit) begin
            c_next.st = ST_IDLE;
          end else begin
            c_next.st = slopeMode ? ST_WAIT_TRIG : ST_SWEEP;
          end
        end
      end
      default: c_next.st = ST_IDLE;
    endcase
    if (c_next.st == ST_SWEEP && c_reg.st != ST_SWEEP) begin
      c_next.addr = ADDR_RESET;
      newSweep = 1'b1;
      c_next.extraCnt = (extraEn && slopeMode && cfg.dlyMode == DLY_POST) ?
                        cfg.markerAddressSetting : 17'h0;
    end
    if (!measureMode) begin
      c_next.st = ST_IDLE;
    end

    // Cursor scaler; feeding the cursor back into reset repeats it
    if (curRstFall) begin
      c_next.curCnt = ADDR_RESET;
    end else if (newSweep) begin
      c_next.curCnt = ADDR_RESET;
    end else if (c_next.strobe) begin
      c_next.curCnt = c_reg.curCnt + 17'h1;
    end
    c_next.curHit = curMatch;
    // A match during a running pulse is absorbed to keep the width fixed
    if (curMatch && !c_reg.curHit && c_reg.curTimer == 16'h0) begin
      c_next.curTimer = 16'(CURSOR_CYCLES);
    end else if (c_reg.curTimer != 16'h0) begin
      c_next.curTimer = c_reg.curTimer - 16'h1;
    end
  end

  // Setting 1 selects address 0; setting 0 disables the cursor
  assign curSrc   = curInhib ? readoutAddr : c_reg.curCnt;
  assign curMatch = (cfg.markerAddressSetting != 17'h0) &&
                    (curInhib || c_reg.st == ST_SWEEP) &&
                    (curSrc == cfg.markerAddressSetting - 17'h1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      c_reg <= '{st: ST_IDLE, addr: ADDR_RESET, extraCnt: ADDR_RESET,
                 sweeps: 24'h0, curCnt: ADDR_RESET, curTimer: 16'h0,
                 default: 1'b0};
    end else begin
      c_reg <= c_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign delayActive  = measureMode && (c_reg.st == ST_PRE_DLY ||
                                        c_reg.st == ST_POST_DLY);
  assign sweepActive  = (c_reg.st == ST_SWEEP);
  assign dwellOut     = c_reg.dwell;
  assign accumStrobe  = c_reg.strobe;
  assign sampleAddr   = c_reg.addr;
  assign cursorOutN   = (c_reg.curTimer == 16'h0);
  assign stopRequest  = c_reg.stopOut;
  assign readoutStart = c_reg.rdStart;
  assign sweepsDone   = c_reg.sweeps;
endmodule : stc_sweep_timebase
`default_nettype wire

// [verilog/stc_pkg.sv]
package stc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned CURSOR_PULSE_US = 2;
  localparam int unsigned CURSOR_CYCLES  = CURSOR_PULSE_US * CLK_MHZ;
  localparam int unsigned EXT_PRESCALE   = 10;
  // Internal timebase: cycles per microsecond (decade 0 = 1 us units)
  localparam int unsigned US_CYCLES      = CLK_MHZ;

  // ------------------------------------------------------------
  // Settings and encodings
  // ------------------------------------------------------------
  localparam logic [2:0] DECADE_EXT_STEP = 3'h7;
  localparam logic [13:0] DIGITS_RESET   = 14'h0000;
  localparam logic [16:0] ADDR_RESET     = 17'h00000;

  typedef enum logic [1:0] {TRIG_AUTO, TRIG_POS, TRIG_NEG} stc_trig_t;
  typedef enum logic [1:0] {DLY_OFF, DLY_PRE, DLY_POST} stc_dly_t;

  typedef enum {
    ST_IDLE, ST_WAIT_TRIG, ST_PRE_DLY, ST_EXTRA, ST_SWEEP, ST_POST_DLY
  } stc_state_t;

  typedef struct packed {
    logic [13:0] dwellDigits;   // 1..9999
    logic [2:0]  dwellDecade;   // 10^n us, or ext step
    logic [13:0] delayDigits;
    logic [2:0]  delayDecade;
    logic [16:0] markerAddressSetting;
    logic [16:0] dataPoints;
    logic [23:0] sweepCountLimit;
    stc_trig_t   trigMode;
    stc_dly_t    dlyMode;
  } stc_cfg_t;

endpackage : stc_pkg

// [verilog/stc_divider.sv]
`timescale 1ns/1ps
`default_nettype none
// Programmable tick divider: one outTick every `divisor` inTicks
module stc_divider (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic        inTick,
  input  wire logic [31:0] divisor,
  output logic             outTick
);
  import stc_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } stc_div_state_t;

  stc_div_state_t s_reg;
  stc_div_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (clear) begin
      s_next.cnt = 32'h0;
    end else if (inTick) begin
      if (s_reg.cnt + 32'h1 >= divisor) begin
        s_next.cnt = 32'h0;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign outTick = s_reg.tick;
endmodule : stc_divider
`default_nettype wire

// [verification/stc_sweep_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module stc_sweep_checker (
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire stc_pkg::stc_cfg_t cfg,
  input wire logic              measureStart,
  input wire logic              measureMode,
  input wire logic              readoutMode,
  input wire logic              extStopN,
  input wire logic              delayActive,
  input wire logic              sweepActive,
  input wire logic              accumStrobe,
  input wire logic [16:0]       sampleAddr,
  input wire logic              cursorOutN,
  input wire logic              stopRequest
);
  import stc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [9:0] lowCnt_reg;
  // Cursor pulse is far longer than any repetition, so count it here
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lowCnt_reg <= 10'h0;
    else lowCnt_reg <= cursorOutN ? 10'h0 : lowCnt_reg + 10'h1;
  end
  sequence autoStart;
    measureStart && measureMode && !sweepActive && !delayActive &&
      cfg.trigMode == TRIG_AUTO && cfg.dlyMode == DLY_OFF;
  endsequence
  sequence stopHeld;
    (!extStopN && (measureMode || readoutMode)) [*6];
  endsequence
  a_delay_in_measure: assert property (
    delayActive |-> measureMode) else $error("delay flag outside measure");
  a_flags_exclusive: assert property (
    !(sweepActive && delayActive)) else $error("sweep and delay together");
  a_cursor_width: assert property (
    $rose(cursorOutN) |-> lowCnt_reg == 10'(CURSOR_CYCLES))
    else $error("cursor pulse width wrong");
  a_no_early_strobe: assert property (
    $rose(sweepActive) && cfg.dwellDecade != DECADE_EXT_STEP
      |-> !accumStrobe [*8]) else $error("strobe before dwell elapsed");
  a_strobe_in_sweep: assert property (
    accumStrobe |-> sweepActive || $past(sweepActive))
    else $error("strobe outside sweep");
  a_addr_steps_one: assert property (
    $changed(sampleAddr) |-> sampleAddr == $past(sampleAddr) + 17'h1 ||
      sampleAddr == 17'h0) else $error("address jumped");
  a_stop_request: assert property (
    stopHeld |-> stopRequest) else $error("stop not requested");
  a_auto_start: assert property (
    autoStart |-> ##[1:2] sweepActive) else $error("auto sweep not started");
endmodule : stc_sweep_checker
bind stc_sweep_timebase stc_sweep_checker chk_u (.*);
`default_nettype wire

// [verification/stc_ext_equip.sv]
`timescale 1ns/1ps
`default_nettype none
module stc_ext_equip (
  input  wire logic sys_clk,
  input  wire logic stepOn,
  input  wire logic loopCursor,
  input  wire logic useExtClk,
  input  wire logic cursorOutN,
  output var logic  ext_step_in,
  output var logic  extClockIn,
  output logic      intClockInhibitN,
  output logic      cursorResetIn
);
  int phase = 0;
  // Two-clock step pulses so the input synchroniser cannot miss them
  always @(negedge sys_clk) begin
    phase <= (phase == 9) ? 0 : phase + 1;
    ext_step_in <= stepOn && phase < 2;
    extClockIn <= useExtClk && phase < 5;
  end
  assign intClockInhibitN = ~useExtClk;
  assign cursorResetIn = loopCursor ? cursorOutN : 1'b1;
endmodule : stc_ext_equip
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stc_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, measureStart = 1'b0;
  stc_cfg_t    cfg = '0;
  logic        measureMode = 1'b1, readoutMode = 1'b0, memCycleDone = 1'b1;
  logic [16:0] readoutAddr = 17'h0;
  logic        extTrigIn = 1'b0, sweepAbortIn = 1'b0, extStopN = 1'b1;
  logic        measCursorInhibitN = 1'b1, readoutTrigIn = 1'b1;
  logic        pre_acq_wait_enableN = 1'b1, stepOn = 1'b1;
  logic        loopCursor = 1'b0, useExtClk = 1'b0, prevCur = 1'b1;
  logic        ext_step_in, extClockIn, intClockInhibitN, cursorResetIn;
  logic        delayActive, sweepActive, dwellOut, accumStrobe;
  logic        cursorOutN, stopRequest, readoutStart;
  logic [16:0] sampleAddr;
  logic [23:0] sweepsDone, prevDone = 24'h0;
  logic [23:0] expQ[$];
  logic [2:0]  mon;
  logic [31:0] seed = 32'h6bb5;
  int          err_count = 0, compares = 0, strobes = 0;
  int          curFalls = 0, roStarts = 0, dwells = 0, i, n;
  assign mon = {stopRequest, sweepActive, delayActive};
  stc_sweep_timebase dut_u (.*);
  stc_ext_equip      equip_u (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic end_of_test();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Readout address wanders at random on every bench cycle
  task automatic cyc(input int k);
    repeat (k) begin
      @(negedge sys_clk);
      seed = xs(seed);
      readoutAddr = seed[16:0];
    end
  endtask : cyc
  task automatic waitFor(input int b, input logic v, input int lim);
    for (int k = 0; k < lim && mon[b] !== v; k++) cyc(1);
    if (mon[b] !== v) begin
      err_count++;
      end_of_test();
    end
  endtask : waitFor
  task automatic waitQ(input int lim);
    for (int k = 0; k < lim && expQ.size() > 0; k++) cyc(1);
    if (expQ.size() > 0) begin
      err_count++;
      end_of_test();
    end
  endtask : waitQ
  task automatic setup(input stc_trig_t t, input stc_dly_t d,
                       input logic [2:0] dec, input logic [16:0] pts,
                       input logic [23:0] lim);
    cfg = '{dwellDigits: 14'h2, dwellDecade: dec, delayDigits: 14'h1,
            delayDecade: 3'h0, markerAddressSetting: 17'h2,
            dataPoints: pts, sweepCountLimit: lim, trigMode: t,
            dlyMode: d};
    extTrigIn = (t == TRIG_POS);
    rstn = 1'b0;
    cyc(4);
    rstn = 1'b1;
    strobes = 0;
    dwells = 0;
    curFalls = 0;
    roStarts = 0;
    cyc(4);
  endtask : setup
  task automatic start();
    measureStart = 1'b1;
    cyc(1);
    measureStart = 1'b0;
  endtask : start
  // ----------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------
  always @(negedge sys_clk) begin
    if (rstn) begin
      strobes += int'(accumStrobe);
      dwells += int'(dwellOut);
      roStarts += int'(readoutStart);
      curFalls += int'(prevCur & ~cursorOutN);
      if (sweepsDone !== prevDone && sweepsDone !== 24'h0 &&
          expQ.size() > 0) begin
        chk(24'(strobes), 24'(cfg.dataPoints) * sweepsDone);
        chk(sweepsDone, expQ.pop_front());
      end
    end
    prevDone = sweepsDone;
    prevCur = cursorOutN;
  end
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  initial begin
    seed = xs(seed);
    n = 2 + int'(seed[1:0]);
    setup(TRIG_AUTO, DLY_OFF, DECADE_EXT_STEP, 17'(n), 24'h3);
    for (i = 1; i <= 3; i++) expQ.push_back(24'(i));
    start();
    cyc(1);
    chk({23'h0, sweepActive}, 24'h1);
    waitQ(3000);
    cyc(50);
    chk({23'h0, sweepActive}, 24'h0);
    chk(sweepsDone, 24'h3);
    // Internal dwell while advance pulses keep arriving
    setup(TRIG_AUTO, DLY_OFF, 3'h0, 17'h3, 24'h1);
    expQ.push_back(24'h1);
    start();
    waitQ(3000);
    cyc(500);
    chk(24'(curFalls), 24'h1);
    chk(24'(dwells), 24'h3);
    // Wrong slope first, then the chosen one, with a pre-delay
    for (i = 0; i < 2; i++) begin
      setup(i ? TRIG_NEG : TRIG_POS, DLY_PRE, DECADE_EXT_STEP, 17'h2, 24'h0);
      expQ.push_back(24'h1);
      start();
      extTrigIn = ~extTrigIn;
      cyc(30);
      chk({21'h0, mon}, 24'h0);
      extTrigIn = ~extTrigIn;
      waitFor(0, 1'b1, 20);
      for (n = 0; delayActive === 1'b1 && n < 300; n++) cyc(1);
      chk(24'(n > 198 && n < 203), 24'h1);
      chk({23'h0, sweepActive}, 24'h1);
      extTrigIn = ~extTrigIn;
      cyc(3);
      extTrigIn = ~extTrigIn;
      waitQ(300);
      cyc(300);
      chk({21'h0, mon}, 24'h0);
    end
    // Abort in mid-sweep, then readout trigger and external stop
    setup(TRIG_POS, DLY_OFF, DECADE_EXT_STEP, 17'h40, 24'h0);
    start();
    extTrigIn = 1'b0;
    cyc(5);
    extTrigIn = 1'b1;
    waitFor(1, 1'b1, 20);
    cyc(10);
    sweepAbortIn = 1'b1;
    cyc(2);
    sweepAbortIn = 1'b0;
    waitFor(1, 1'b0, 12);
    chk({23'h0, sweepActive}, 24'h0);
    // Readout start is only honoured in readout operation
    readoutMode = 1'b1;
    cyc(1);
    readoutTrigIn = 1'b0;
    cyc(10);
    chk(24'(roStarts), 24'h1);
    extStopN = 1'b0;
    cyc(10);
    chk({23'h0, stopRequest}, 24'h1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
